// >>> tw_brg.sv
// Bit-rate generator: two ticks per bus clock period
`timescale 1ns/1ns
`default_nettype none
module tw_brg (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic hold,
  input wire logic [tw_pkg::BRG_W-1:0] reload,
  output logic tick
);
  // Down counter and tick flop
  typedef struct packed {
    logic [tw_pkg::BRG_W-1:0] cnt;
    logic tick;
  } tw_brg_st_t;
  tw_brg_st_t r, nx;
  logic [tw_pkg::BRG_W-1:0] per;
  // Period is reload + 1 + rise delay cycles
  always_comb
  begin
    per = reload + tw_pkg::BRG_W'(tw_pkg::RISE_DLY_CYC); // see RULE_01 RULE_22
    nx = r;
    nx.tick = 1'b0;
    if (hold)
      nx.cnt = per;
    else if (run)
    begin
      // Tick mid-period and at the end
      if (r.cnt == '0)
        nx.cnt = per;
      else
        nx.cnt = r.cnt - 1'b1;
      nx.tick = (r.cnt == '0) || (r.cnt == (per >> 1));
    end
  end
  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else if (ce)
      r <= nx;
  end
  assign tick = r.tick;
endmodule
`default_nettype wire

// >>> tw_ctl.sv
// Two-wire bus controller: registers, master sequencer, slave engine
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module tw_ctl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cpu_idle,
  input wire tw_pkg::tw_req_t req,
  output logic [15:0] rdata,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic port_owns_pins,
  output logic slew_control_off,
  output logic smbus_input_levels,
  output logic master_done,
  output logic slave_event
);
  // Whole controller state
  typedef struct packed {
    logic [15:0] ctrl;
    logic [9:0] mask;
    logic [tw_pkg::BRG_W-1:0] brg;
    logic [9:0] oadr;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic [15:0] rdata;
    tw_pkg::tw_mst_t ms;
    logic [1:0] mph;
    logic [3:0] mbit;
    logic [7:0] msh;
    logic m_own;
    tw_pkg::tw_pins_t mdrv;
    logic ack_stat;
    logic rx_full;
    tw_pkg::tw_slv_t ss;
    tw_pkg::tw_slv_t s_tgt;
    logic [7:0] ssh;
    logic [3:0] sbit;
    logic scl_q;
    logic sda_q;
    logic s_rw;
    logic s_nak;
    logic ten_seen;
    logic gc_stat;
    logic s_sda;
    logic mdone;
    logic sev;
  } tw_st_t;
  tw_st_t q, n;
  logic [1:0] pin_s; // Synchronised {scl, sda}
  logic scl_s, sda_s;
  logic eng; // Engine running
  logic tick; // Half-period tick
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [6:0] a7;
  logic rw, rsv, gc, up, ok7, lo_ok;
  logic hold_scl;
  logic [15:0] stat;

  // Pin synchroniser
  tw_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d({scl_in, sda_in}),
    .q(pin_s)
  );
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  // Engine runs when on and not halted by idle
  assign eng = q.ctrl[tw_pkg::B_ON] & ~(q.ctrl[tw_pkg::B_SIDL] & cpu_idle); // see RULE_08

  // Bit-rate generator, parked while master idles
  tw_brg u_brg (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .run(eng),
    .hold(q.ms == tw_pkg::TW_M_IDLE),
    .reload(q.brg),
    .tick(tick)
  );

  // Bus edge and condition detection
  assign scl_rise = scl_s & ~q.scl_q;
  assign scl_fall = ~scl_s & q.scl_q;
  assign bus_start = scl_s & q.scl_q & q.sda_q & ~sda_s;
  assign bus_stop = scl_s & q.scl_q & ~q.sda_q & sda_s;

  // Decode of the byte shifted in
  always_comb
  begin
    a7 = q.ssh[7:1];
    rw = q.ssh[0];
    // Reserved: 0000001..00001xx and 11111xx
    rsv = ((a7[6:3] == 4'h0) && (a7 != 7'h00)) || (a7[6:2] == tw_pkg::RSV_HI); // see RULE_04
    gc = (a7 == 7'h00) && !rw && q.ctrl[tw_pkg::B_GENERAL_CALL_ENABLE]; // see RULE_05
    // Upper ten-bit byte only in ten-bit mode
    up = q.ctrl[tw_pkg::B_TEN] && (a7[6:2] == tw_pkg::UPPER10)
      && (((a7[1:0] ^ q.oadr[9:8]) & ~q.mask[9:8]) == 2'h0); // see RULE_06 RULE_02
    ok7 = !q.ctrl[tw_pkg::B_TEN] && !rsv && (a7 != 7'h00)
      && (a7[6:2] != tw_pkg::UPPER10)
      && (((a7 ^ q.oadr[6:0]) & ~q.mask[6:0]) == 7'h00); // see RULE_02 RULE_13
    lo_ok = ((q.ssh ^ q.oadr[7:0]) & ~q.mask[7:0]) == 8'h00; // see RULE_02
  end

  // Status word
  always_comb
  begin
    stat = 16'h0000;
    stat[tw_pkg::S_RXF] = q.rx_full;
    stat[tw_pkg::S_ACK] = q.ack_stat;
    stat[tw_pkg::S_MBSY] = q.ms != tw_pkg::TW_M_IDLE;
    stat[tw_pkg::S_SACT] = (q.ss == tw_pkg::TW_S_RX) || (q.ss == tw_pkg::TW_S_TX);
    stat[tw_pkg::S_RW] = q.s_rw;
    stat[tw_pkg::S_GC] = q.gc_stat;
    stat[tw_pkg::S_TEN] = q.ten_seen;
    stat[tw_pkg::S_OWN] = q.m_own;
  end

  // Next-state logic
  always_comb
  begin
    n = q;
    n.rdata = 16'h0000;
    n.mdone = 1'b0;
    n.sev = 1'b0;
    n.scl_q = scl_s;
    n.sda_q = sda_s;
    // Register writes
    if (req.wr)
    begin
      unique case (req.addr)
        tw_pkg::OFS_CTRL:
        begin
          n.ctrl = req.wdata & tw_pkg::CTRL_WMASK; // see RULE_23 RULE_17
          // Zero to release ignored unless stretching
          if (!q.ctrl[tw_pkg::B_STR] && !req.wdata[tw_pkg::B_REL])
            n.ctrl[tw_pkg::B_REL] = q.ctrl[tw_pkg::B_REL]; // see RULE_11 RULE_16
        end
        tw_pkg::OFS_MASK: n.mask = req.wdata[9:0];
        tw_pkg::OFS_BRG: n.brg = req.wdata[tw_pkg::BRG_W-1:0];
        tw_pkg::OFS_ADDR: n.oadr = req.wdata[9:0];
        tw_pkg::OFS_TX:
        begin
          n.txd = req.wdata[7:0];
          // Owned idle bus: write launches a master byte
          if (q.m_own && q.ms == tw_pkg::TW_M_IDLE && eng)
          begin
            n.ms = tw_pkg::TW_M_TX;
            n.msh = req.wdata[7:0];
            n.mbit = 4'h0;
            n.mph = 2'h0;
            n.mdrv.sda = ~req.wdata[7];
          end
        end
        default: ; // Unmapped writes ignored
      endcase
    end
    // Register reads, answered next cycle
    if (req.rd)
    begin
      unique case (req.addr)
        tw_pkg::OFS_CTRL: n.rdata = q.ctrl;
        tw_pkg::OFS_STAT: n.rdata = stat;
        tw_pkg::OFS_MASK: n.rdata = {6'h00, q.mask};
        tw_pkg::OFS_BRG: n.rdata = {{(16 - tw_pkg::BRG_W){1'b0}}, q.brg};
        tw_pkg::OFS_ADDR: n.rdata = {6'h00, q.oadr};
        tw_pkg::OFS_TX: n.rdata = {8'h00, q.txd};
        tw_pkg::OFS_RX:
        begin
          n.rdata = {8'h00, q.rxd};
          n.rx_full = 1'b0; // Read empties; a new byte wins below
        end
        default: n.rdata = 16'h0000;
      endcase
    end

    if (!q.ctrl[tw_pkg::B_ON])
    begin
      // Off: engines parked, pins let go
      n.ms = tw_pkg::TW_M_IDLE;
      n.ss = tw_pkg::TW_S_IDLE;
      n.mdrv = '0;
      n.s_sda = 1'b0;
      n.m_own = 1'b0;
    end
    else if (eng)
    begin
      // Master sequencer: idle takes requests at once, other states one step per tick
      unique case (q.ms)
        tw_pkg::TW_M_IDLE:
        begin
          n.mph = 2'h0;
          n.mbit = 4'h0;
          // Requests taken in fixed priority
          if (q.ctrl[tw_pkg::B_STGO])
            n.ms = tw_pkg::TW_M_START;
          else if (q.ctrl[tw_pkg::B_RSTGO])
            n.ms = tw_pkg::TW_M_RSTART;
          else if (q.ctrl[tw_pkg::B_STOPGO])
            n.ms = tw_pkg::TW_M_STOP;
          else if (q.ctrl[tw_pkg::B_RCVGO])
          begin
            n.ms = tw_pkg::TW_M_RX;
            n.mdrv.sda = 1'b0;
          end
          else if (q.ctrl[tw_pkg::B_ACKGO])
          begin
            n.ms = tw_pkg::TW_M_ACK;
            n.mdrv.sda = ~q.ctrl[tw_pkg::B_ACKV]; // see RULE_19
          end
        end
        tw_pkg::TW_M_START:
          if (tick)
          begin
            n.mph = q.mph + 2'h1;
            n.m_own = 1'b1;
            // Data falls with clock high, then clock falls
            if (q.mph == 2'h0)
              n.mdrv.sda = 1'b1;
            else
            begin
              n.mdrv.scl = 1'b1;
              n.ctrl[tw_pkg::B_STGO] = 1'b0; // see RULE_21
              n.ms = tw_pkg::TW_M_IDLE;
              n.mdone = 1'b1;
            end
          end
        tw_pkg::TW_M_RSTART:
          if (tick && (q.mph != 2'h1 || scl_s || !q.mdrv.scl))
          begin
            n.mph = q.mph + 2'h1;
            // Release data, release clock, drop data, drop clock
            unique case (q.mph)
              2'h0: n.mdrv.sda = 1'b0;
              2'h1: n.mdrv.scl = 1'b0;
              2'h2: n.mdrv.sda = 1'b1;
              2'h3:
              begin
                n.mdrv.scl = 1'b1;
                n.ctrl[tw_pkg::B_RSTGO] = 1'b0; // see RULE_21
                n.ms = tw_pkg::TW_M_IDLE;
                n.mdone = 1'b1;
              end
            endcase
          end
        tw_pkg::TW_M_STOP:
          if (tick)
          begin
            n.mph = q.mph + 2'h1;
            // Drop data, release clock, release data
            if (q.mph == 2'h0)
              n.mdrv.sda = 1'b1;
            else if (q.mph == 2'h1)
              n.mdrv.scl = 1'b0;
            else
            begin
              n.mdrv.sda = 1'b0;
              n.m_own = 1'b0;
              n.ctrl[tw_pkg::B_STOPGO] = 1'b0; // see RULE_21
              n.ms = tw_pkg::TW_M_IDLE;
              n.mdone = 1'b1;
            end
          end
        default:
          // Shared bit engine
          if (tick)
          begin
            if (q.mph == 2'h0)
            begin
              n.mdrv.scl = 1'b0;
              n.mph = 2'h1;
            end
            else if (scl_s)
            begin
              // Clock seen high: sample, then drop clock
              n.mdrv.scl = 1'b1;
              n.mph = 2'h0;
              n.mbit = q.mbit + 4'h1;
              n.msh = {q.msh[6:0], sda_s};
              if (q.ms == tw_pkg::TW_M_TX)
              begin
                if (q.mbit == 4'h8)
                begin
                  n.ack_stat = sda_s;
                  n.ms = tw_pkg::TW_M_IDLE;
                  n.mdone = 1'b1;
                end
                else
                  n.mdrv.sda = (q.mbit == 4'h7) ? 1'b0 : ~q.msh[6];
              end
              else if (q.ms == tw_pkg::TW_M_RX)
              begin
                if (q.mbit == 4'h7)
                begin
                  n.rxd = {q.msh[6:0], sda_s};
                  n.rx_full = 1'b1;
                  n.ctrl[tw_pkg::B_RCVGO] = 1'b0; // see RULE_20
                  n.ms = tw_pkg::TW_M_IDLE;
                  n.mdone = 1'b1;
                end
              end
              else
              begin
                n.mdrv.sda = 1'b0;
                n.ctrl[tw_pkg::B_ACKGO] = 1'b0; // see RULE_19
                n.ms = tw_pkg::TW_M_IDLE;
                n.mdone = 1'b1;
              end
            end
          end
      endcase

      // Slave engine
      if (bus_start)
      begin
        n.ss = tw_pkg::TW_S_ADR;
        n.sbit = 4'h0;
        n.s_sda = 1'b0;
      end
      else if (bus_stop)
      begin
        n.ss = tw_pkg::TW_S_IDLE;
        n.s_sda = 1'b0;
        n.gc_stat = 1'b0;
        n.ten_seen = 1'b0;
      end
      else if (q.ss != tw_pkg::TW_S_IDLE)
      begin
        if (scl_rise)
        begin
          // Receive counts bits on rises; transmit takes the ack
          if (q.ss != tw_pkg::TW_S_TX && q.sbit < 4'h8)
          begin
            n.ssh = {q.ssh[6:0], sda_s};
            n.sbit = q.sbit + 4'h1;
          end
          if (q.ss == tw_pkg::TW_S_TX && q.sbit == 4'h8)
            n.s_nak = sda_s;
        end
        else if (scl_fall && q.ss == tw_pkg::TW_S_TX)
        begin
          if (q.sbit < 4'h7)
          begin
            n.sbit = q.sbit + 4'h1;
            n.ssh = {q.ssh[6:0], 1'b0};
            n.s_sda = ~q.ssh[6];
          end
          else if (q.sbit == 4'h7)
          begin
            n.sbit = 4'h8;
            n.s_sda = 1'b0;
          end
          else if (q.s_nak)
            n.ss = tw_pkg::TW_S_IDLE;
          else
          begin
            // Next byte: stretch for data
            n.sbit = 4'h0;
            n.ctrl[tw_pkg::B_REL] = 1'b0; // see RULE_10 RULE_11
            n.sev = 1'b1;
          end
        end
        else if (scl_fall && q.sbit == 4'h8)
        begin
          // Ack decision after eighth bit
          n.sbit = 4'h9;
          n.s_sda = 1'b1;
          n.s_tgt = tw_pkg::TW_S_IDLE;
          n.sev = 1'b1;
          unique case (q.ss)
            tw_pkg::TW_S_ADR:
            begin
              n.s_rw = rw;
              if (q.ctrl[tw_pkg::B_ALL]) // see RULE_12 RULE_03
                n.s_tgt = rw ? tw_pkg::TW_S_TX : tw_pkg::TW_S_RX;
              else if (gc)
              begin
                n.gc_stat = 1'b1; // see RULE_15
                n.s_tgt = tw_pkg::TW_S_RX;
              end
              else if (ok7)
                n.s_tgt = rw ? tw_pkg::TW_S_TX : tw_pkg::TW_S_RX;
              else if (up && !rw)
                n.s_tgt = tw_pkg::TW_S_ADR2;
              else if (up && rw && q.ten_seen)
                n.s_tgt = tw_pkg::TW_S_TX;
              else
              begin
                n.s_sda = 1'b0; // No match: no acknowledge
                n.sev = 1'b0;
                n.ss = tw_pkg::TW_S_IDLE;
              end
            end
            tw_pkg::TW_S_ADR2:
              if (lo_ok)
              begin
                n.ten_seen = 1'b1;
                n.s_tgt = tw_pkg::TW_S_RX;
              end
              else
              begin
                n.s_sda = 1'b0;
                n.sev = 1'b0;
                n.ss = tw_pkg::TW_S_IDLE;
              end
            default:
            begin
              // Data byte received
              n.rxd = q.ssh;
              n.rx_full = 1'b1;
              n.s_tgt = tw_pkg::TW_S_RX;
            end
          endcase
        end
        else if (scl_fall && q.sbit == 4'h9)
        begin
          // End of acknowledge bit
          n.sbit = 4'h0;
          n.s_sda = 1'b0;
          n.ss = q.s_tgt;
          if (q.s_tgt == tw_pkg::TW_S_TX)
            n.ctrl[tw_pkg::B_REL] = 1'b0; // see RULE_10 RULE_11
          else if (q.ss == tw_pkg::TW_S_RX && q.ctrl[tw_pkg::B_STR])
            n.ctrl[tw_pkg::B_REL] = 1'b0; // see RULE_10 RULE_16
        end
      end
      // Stretched before a byte: track transmit data
      if (n.ss == tw_pkg::TW_S_TX && n.sbit == 4'h0 && !n.ctrl[tw_pkg::B_REL] && !scl_s)
      begin
        n.ssh = n.txd;
        n.s_sda = ~n.txd[7];
        n.s_nak = 1'b0;
      end
    end
  end

  // Slave clock hold while release bit is zero
  assign hold_scl = ~q.ctrl[tw_pkg::B_REL] & ~q.scl_q
    & ((q.ss == tw_pkg::TW_S_RX) | (q.ss == tw_pkg::TW_S_TX)); // see RULE_09

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.ctrl <= tw_pkg::CTRL_RST; // see RULE_09
      q.scl_q <= 1'b1;
      q.sda_q <= 1'b1;
    end
    else if (ce)
      q <= n;
  end

  // Open drain: pins pulled only while on
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = q.ctrl[tw_pkg::B_ON] & (q.mdrv.scl | hold_scl); // see RULE_07
  assign sda_oe = q.ctrl[tw_pkg::B_ON] & (q.mdrv.sda | q.s_sda); // see RULE_07
  assign port_owns_pins = ~q.ctrl[tw_pkg::B_ON]; // see RULE_07
  assign slew_control_off = q.ctrl[tw_pkg::B_SLEW]; // see RULE_14
  assign smbus_input_levels = q.ctrl[tw_pkg::B_SMB]; // see RULE_14
  assign master_done = q.mdone;
  assign slave_event = q.sev;
  assign rdata = q.rdata;
endmodule
`default_nettype wire

// >>> tw_ctl_properties.sv
// Port checks for the two-wire bus controller
`timescale 1ns/1ns
`default_nettype none
module tw_ctl_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire tw_pkg::tw_req_t req,
  input wire logic [15:0] rdata,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic port_owns_pins,
  input wire logic slew_control_off,
  input wire logic smbus_input_levels,
  input wire logic master_done,
  input wire logic slave_event
);
  // One clock domain, one reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Pads carry bits 9, 8
  a_pads_follow_ctrl: assert property (
    req.wr && req.addr == tw_pkg::OFS_CTRL |-> ##2
    {slew_control_off, smbus_input_levels} == $past(req.wdata[9:8], 2))
    else $error("pads differ from control");
  // Ownership follows enable
  a_pins_follow_on: assert property (
    req.wr && req.addr == tw_pkg::OFS_CTRL |-> ##2
    port_owns_pins == !$past(req.wdata[15], 2))
    else $error("ownership differs from enable");
  // Off block pulls no line
  a_lines_free_off: assert property (
    port_owns_pins [*3] |-> !scl_oe && !sda_oe)
    else $error("line pulled while off");
  // Zero read data between answers
  a_rdata_idle_zero: assert property (
    !$past(req.rd) |-> rdata == 16'h0000)
    else $error("stray read data");
  // Bit 14 reads zero
  a_bit14_zero: assert property (
    $past(req.rd && req.addr == tw_pkg::OFS_CTRL) |-> !rdata[14])
    else $error("control bit 14 reads one");
  // Unmapped index reads zero
  a_unmapped_zero: assert property (
    $past(req.rd && req.addr == 3'h7) |-> rdata == 16'h0000)
    else $error("unmapped read nonzero");
  // Done is one pulse
  a_done_pulse: assert property (
    master_done |=> !master_done)
    else $error("done pulse too long");
  // Event is one pulse
  a_event_pulse: assert property (
    $rose(slave_event) |=> $fell(slave_event))
    else $error("event pulse too long");
endmodule
`default_nettype wire

// >>> tw_ctl_test.sv
// Bench for the two-wire bus controller
`timescale 1ns/1ns
`default_nettype none
module tw_ctl_test;
  logic clk; // System clock
  logic rst_n; // Active low reset
  logic ce; // Clock enable
  logic cpu_idle; // Device idle flag
  tw_pkg::tw_req_t req; // Register port request
  logic [15:0] rdata;
  logic scl_oe, sda_oe;
  logic scl_low; // Far side pulls clock
  logic sda_low; // Far side pulls data
  wire logic scl = !(scl_oe || scl_low); // Wired-AND with pull-up
  wire logic sda = !(sda_oe || sda_low);
  logic master_done, slave_event;
  int err_count, check_count;
  int ev_cnt; // Slave events so far
  int cyc, last;
  int per; // Cycles between clock pulls
  logic oe_q;
  logic [15:0] d;
  logic [6:0] rsv [5] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h7C}; // Reserved addresses
  tw_ctl tw_ctl_i (.clk(clk), .rst_n(rst_n), .ce(ce), .cpu_idle(cpu_idle), .req(req),
    .rdata(rdata), .scl_in(scl), .sda_in(sda), .scl_out(), .scl_oe(scl_oe), .sda_out(),
    .sda_oe(sda_oe), .port_owns_pins(), .slew_control_off(), .smbus_input_levels(),
    .master_done(master_done), .slave_event(slave_event));
  tw_host_model tw_host_model_i (.clk(clk), .scl(scl), .sda(sda), .scl_low(scl_low),
    .sda_low(sda_low));
  // Clock
  always #5 clk = ~clk;
  // Cycles, pull period, events
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    oe_q <= scl_oe;
    if (slave_event === 1'b1)
      ev_cnt <= ev_cnt + 1;
    if (scl_oe === 1'b1 && oe_q === 1'b0)
    begin
      per <= cyc - last;
      last <= cyc;
    end
  end
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Register write cycle
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
  endtask
  // Register read
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  // Bounded wait for master done
  task automatic wait_done();
    int n = 0;
    while (master_done !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 5000)
    begin
      err_count++;
      finish_test();
    end
    @(posedge clk);
  endtask
  // Far side addresses the slave
  task automatic sframe(input logic [15:0] c, input logic [9:0] own, input logic [9:0] msk,
    input logic [7:0] b, input logic idle, input logic exp);
    logic ack;
    int e0;
    wr(tw_pkg::OFS_CTRL, 16'h9000 | c);
    wr(tw_pkg::OFS_ADDR, {6'h00, own});
    wr(tw_pkg::OFS_MASK, {6'h00, msk});
    cpu_idle <= idle;
    e0 = ev_cnt;
    tw_host_model_i.frame(b, ack);
    cpu_idle <= 1'b0;
    chk("ack", 16'(exp), 16'(ack));
    if (!c[10])
      chk("event", 16'(exp), 16'(ev_cnt != e0));
    $display("test done: frame %h", b);
  endtask
  // Main sequence
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    cpu_idle = 1'b0;
    req = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(tw_pkg::OFS_CTRL, d);
    chk("ctrl reset", 16'h1000, d);
    wr(tw_pkg::OFS_CTRL, 16'h0000);
    rd(tw_pkg::OFS_CTRL, d);
    chk("release kept", 16'h1000, d);
    wr(tw_pkg::OFS_CTRL, 16'h1040);
    wr(tw_pkg::OFS_CTRL, 16'h0040);
    rd(tw_pkg::OFS_CTRL, d);
    chk("release cleared", 16'h0040, d);
    wr(tw_pkg::OFS_CTRL, 16'h7FE0);
    rd(tw_pkg::OFS_CTRL, d);
    chk("ctrl bits", 16'h3FE0, d);
    rd(3'h7, d);
    chk("unmapped", 16'h0000, d);
    $display("test done: registers");
    sframe(16'h0000, 10'h052, 10'h000, 8'hA4, 1'b0, 1'b1);
    sframe(16'h0000, 10'h052, 10'h000, 8'hA6, 1'b0, 1'b0);
    sframe(16'h0000, 10'h052, 10'h001, 8'hA6, 1'b0, 1'b1);
    for (int i = 0; i < 5; i++)
      sframe(16'h0000, {3'h0, rsv[i]}, 10'h000, {rsv[i], 1'b0}, 1'b0, 1'b0);
    sframe(16'h0000, 10'h005, 10'h007, 8'h02, 1'b0, 1'b0);
    sframe(16'h0000, 10'h052, 10'h000, 8'h00, 1'b0, 1'b0);
    sframe(16'h0080, 10'h052, 10'h000, 8'h00, 1'b0, 1'b1);
    sframe(16'h0080, 10'h052, 10'h000, 8'h01, 1'b0, 1'b0);
    sframe(16'h0800, 10'h052, 10'h000, 8'h66, 1'b0, 1'b1);
    sframe(16'h0000, 10'h078, 10'h000, 8'hF0, 1'b0, 1'b0);
    sframe(16'h0400, 10'h2A5, 10'h000, 8'hF4, 1'b0, 1'b1);
    sframe(16'h2000, 10'h052, 10'h000, 8'hA4, 1'b1, 1'b0);
    wr(tw_pkg::OFS_ADDR, 16'h0011);
    wr(tw_pkg::OFS_BRG, 16'h0004);
    wr(tw_pkg::OFS_CTRL, 16'h9001);
    wait_done();
    rd(tw_pkg::OFS_CTRL, d);
    chk("start cleared", 16'h9000, d);
    wr(tw_pkg::OFS_TX, 16'h0020);
    wait_done();
    chk("bit period", 16'h000F, per[15:0]);
    wr(tw_pkg::OFS_CTRL, 16'h9004);
    wait_done();
    rd(tw_pkg::OFS_CTRL, d);
    chk("stop cleared", 16'h9000, d);
    $display("test done: master");
    finish_test();
  end
endmodule
bind tw_ctl tw_ctl_properties tw_ctl_properties_i (.clk(clk), .rst_n(rst_n), .req(req),
  .rdata(rdata), .scl_oe(scl_oe), .sda_oe(sda_oe), .port_owns_pins(port_owns_pins),
  .slew_control_off(slew_control_off), .smbus_input_levels(smbus_input_levels),
  .master_done(master_done), .slave_event(slave_event));
`default_nettype wire

// >>> tw_host_model.sv
// Far-side bus master: start, one byte, stop
`timescale 1ns/1ns
`default_nettype none
module tw_host_model (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output var logic scl_low,
  output var logic sda_low
);
  localparam int HALF = 20; // Half bus period in cycles
  // Lines released at start
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Half period, waiting out stretching
  task automatic half();
    repeat (HALF) @(posedge clk);
    for (int k = 0; k < 400 && !scl_low && scl !== 1'b1; k++)
      @(posedge clk);
  endtask
  // Whole frame; ack set when ninth bit pulled low
  task automatic frame(input logic [7:0] b, output logic ack);
    logic [8:0] bits;
    bits = {b, 1'b1};
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b1;
    // MSB first; ninth bit released for ack
    for (int i = 8; i >= 0; i--)
    begin
      sda_low <= !bits[i];
      half();
      scl_low <= 1'b0;
      half();
      ack = !sda;
      scl_low <= 1'b1;
    end
    // Stop: data rises while clock is high
    half();
    sda_low <= 1'b1;
    half();
    scl_low <= 1'b0;
    half();
    sda_low <= 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

// >>> tw_pkg.sv
// Constants and types for the two-wire bus controller
// Contract
// RULE_01: Bit clock equals clock over reload plus one plus ten
// RULE_02: Set mask bits skip address compare positions
// RULE_03: Masking applies only with accept-all mode off
// RULE_04: Reserved seven-bit addresses never match
// RULE_05: General call acked only when enabled
// RULE_06: Upper ten-bit pattern matches only in ten-bit mode
// RULE_07: Enable bit owns pins; clear returns them
// RULE_08: Halt-in-idle stops engine while device idles
// RULE_09: Release bit resets high; zero holds clock low
// RULE_10: Stretch on: hardware clears at transmit, receive end
// RULE_11: Stretch off: zero writes ignored, clear at transmit
// RULE_12: Accept-all mode acknowledges every address
// RULE_13: Ten-bit bit selects own address width
// RULE_14: Bits nine, eight drive pad configuration outputs
// RULE_15: General call reception raises slave event
// RULE_16: Stretch enable gates software and receive stretching
// RULE_17: Five request bits writable, cleared by hardware
// RULE_18: Software issues write-then-read sequence in order
// RULE_19: Acknowledge request sends chosen value, then clears
// RULE_20: Receive request takes one byte, clears after eight
// RULE_21: Start, restart, stop requests clear when done
// RULE_22: Rise detection delay added to period count
// RULE_23: Bit fourteen reads zero, ignores writes
package tw_pkg;
  // Register indices on the plain port
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_STAT = 3'h1;
  localparam logic [2:0] OFS_MASK = 3'h2;
  localparam logic [2:0] OFS_BRG = 3'h3;
  localparam logic [2:0] OFS_ADDR = 3'h4;
  localparam logic [2:0] OFS_TX = 3'h5;
  localparam logic [2:0] OFS_RX = 3'h6;
  // Control word bit positions
  localparam int B_ON = 15;
  localparam int B_SIDL = 13;
  localparam int B_REL = 12;
  localparam int B_ALL = 11;
  localparam int B_TEN = 10;
  localparam int B_SLEW = 9;
  localparam int B_SMB = 8;
  localparam int B_GENERAL_CALL_ENABLE = 7;
  localparam int B_STR = 6;
  localparam int B_ACKV = 5;
  localparam int B_ACKGO = 4;
  localparam int B_RCVGO = 3;
  localparam int B_STOPGO = 2;
  localparam int B_RSTGO = 1;
  localparam int B_STGO = 0;
  // Control reset value and writable bits
  localparam logic [15:0] CTRL_RST = 16'h1000;
  localparam logic [15:0] CTRL_WMASK = 16'hBFFF;
  // Status bit positions
  localparam int S_RXF = 0;
  localparam int S_ACK = 1;
  localparam int S_MBSY = 2;
  localparam int S_SACT = 3;
  localparam int S_RW = 4;
  localparam int S_GC = 5;
  localparam int S_TEN = 6;
  localparam int S_OWN = 7;
  // Widths
  localparam int BRG_W = 12;
  localparam int SYNC_W = 2;
  // Timing: clock-line rise detection delay
  localparam int CLK_NS = 10;
  localparam int RISE_DLY_NS = 100;
  localparam int RISE_DLY_CYC = (RISE_DLY_NS + CLK_NS - 1) / CLK_NS;
  // Address patterns
  localparam logic [4:0] UPPER10 = 5'h1E;
  localparam logic [4:0] RSV_HI = 5'h1F;
  // Master sequencer states
  typedef enum logic [2:0] {
    TW_M_IDLE, TW_M_START, TW_M_RSTART, TW_M_STOP, TW_M_TX, TW_M_RX, TW_M_ACK
  } tw_mst_t;
  // Slave states
  typedef enum logic [2:0] {
    TW_S_IDLE, TW_S_ADR, TW_S_ADR2, TW_S_RX, TW_S_TX
  } tw_slv_t;
  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tw_req_t;
  // Open-drain pin drive: one means pull low
  typedef struct packed {
    logic scl;
    logic sda;
  } tw_pins_t;
endpackage

// >>> tw_sync.sv
// Two-stage synchroniser for the bus pins
`timescale 1ns/1ns
`default_nettype none
module tw_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [tw_pkg::SYNC_W-1:0] d,
  output logic [tw_pkg::SYNC_W-1:0] q
);
  // Both stages; lines idle high
  typedef struct packed {
    logic [tw_pkg::SYNC_W-1:0] s1;
    logic [tw_pkg::SYNC_W-1:0] s2;
  } tw_sync_st_t;
  tw_sync_st_t r, nx;
  // Per-bit shift; stage one feeds stage two only
  genvar i;
  for (i = 0; i < tw_pkg::SYNC_W; i++) begin : g_bit
    always_comb
    begin
      nx.s1[i] = d[i];
      nx.s2[i] = r.s1[i];
    end
  end
  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '1;
    else if (ce)
      r <= nx;
  end
  assign q = r.s2;
endmodule
`default_nettype wire
